// File: core/pmtr_pkg.sv
// Package of constants and carrier types for the program memory table-read block
package pmtr_pkg;

  // Reset entry point of the program
  localparam logic [15:0] PMTR_RESET_VECTOR = 16'h0000;
  // Word width, default (minimum) depth and maximum depth
  localparam int          PMTR_WORD_W       = 16;
  localparam int          PMTR_DEPTH_MIN    = 8192;
  localparam int          PMTR_DEPTH_MAX    = 65536;
  // Byte field positions inside a program word
  localparam int          PMTR_LO_LSB       = 0;
  localparam int          PMTR_HI_LSB       = 8;
  // Reset value of the high-byte holding register
  localparam logic [7:0]  PMTR_HOLD_RESET   = 8'h00;
  // Data sector that the basic table read may reach
  localparam logic [7:0]  PMTR_SECTOR_BASIC = 8'h00;
  // Cycles a table instruction occupies
  localparam int          PMTR_TABLE_CYCLES = 2;
  // Two-flop synchroniser depth for pins
  localparam int          PMTR_SYNC_STAGES  = 2;

  // Kind of table instruction requested by the core
  typedef enum logic [3:0] {
    PMTR_OP_NONE   = 4'h1,
    PMTR_OP_BASIC  = 4'h2,
    PMTR_OP_EXT    = 4'h4,
    PMTR_OP_PAGE   = 4'h8
  } pmtr_op_type;

  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    PMTR_ST_RESET = 3'h1,
    PMTR_ST_FETCH = 3'h2,
    PMTR_ST_TABLE = 3'h4
  } pmtr_state_type;

  // Table-read request from the core
  typedef struct packed {
    logic        valid;     // One-cycle request
    logic        extended;  // Extended form, any sector
    logic        alt;       // Alternate (last-page) form
    logic [7:0]  dest_addr; // Destination register in the sector
    logic [7:0]  dest_sect; // Destination sector
  } pmtr_req_type;

  // Write of the destination data register
  typedef struct packed {
    logic        valid;     // One-cycle write strobe
    logic [7:0]  dest_addr; // Target register
    logic [7:0]  dest_sect; // Target sector
    logic [7:0]  data;      // Low table byte
  } pmtr_wr_type;

endpackage : pmtr_pkg

// File: core/pmtr_rom.sv
// Program word memory with a registered read port and a load port
`timescale 1ns/10ps
`default_nettype none
module pmtr_rom
  import pmtr_pkg::*;
#(
  parameter int ADDR_W = 13
) (
  input  wire  logic              clk,
  input  wire  logic              wr_en,
  input  wire  logic [ADDR_W-1:0] wr_addr,
  input  wire  logic [15:0]       wr_data,
  input  wire  logic [ADDR_W-1:0] rd_addr,
  output var   logic [15:0]       rd_data
);

  // Word storage, no reset so it maps onto a memory macro
  logic [15:0] mem [0:(1<<ADDR_W)-1];

  // Load port and registered read
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule : pmtr_rom
`default_nettype wire

// File: core/pmtr_sync.sv
// Two-flop synchroniser for one pin level
`timescale 1ns/10ps
`default_nettype none
module pmtr_sync
  import pmtr_pkg::*;
(
  input  wire  logic clk,
  input  wire  logic rst,
  input  wire  logic d,
  output var   logic q
);

  // First stage is read by the second stage only
  logic meta;

  // Plain two-stage shift
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= 1'b0;
      q    <= 1'b0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule : pmtr_sync
`default_nettype wire

// File: core/pmtr_top.sv
// Program memory with instruction fetch, table read and serial programming port
`timescale 1ns/10ps
`default_nettype none
module pmtr_top
  import pmtr_pkg::*;
#(
  parameter int DEPTH    = PMTR_DEPTH_MIN,       // Words, 8K to 64K
  parameter int ADDR_W   = $clog2(DEPTH),         // Word address width
  parameter int HI_BITS  = 8                      // Implemented high-byte bits
) (
  input  wire  logic              CLK_SYS,
  input  wire  logic              RST,
  // Instruction fetch from the core
  input  wire  logic [ADDR_W-1:0] FETCH_ADDR,
  output var   logic [15:0]       FETCH_DATA,
  output var   logic              FETCH_VALID,
  output var   logic              FETCH_STALL,
  // Table pointers held by the core
  input  wire  logic [7:0]        TABLE_PTR_LO,
  input  wire  logic [7:0]        TABLE_PTR_HI,
  // Table-read request and destination write
  input  wire  pmtr_req_type      TABLE_REQ,
  output var   pmtr_wr_type       TABLE_WR,
  output var   logic              TABLE_BUSY,
  output var   logic              TABLE_REJECT,
  // Software access to the high-byte holding register
  input  wire  logic              HOLD_WR,
  input  wire  logic [7:0]        HOLD_WDATA,
  output var   logic [7:0]        TABLE_HIGH_BYTE_HOLD,
  // Serial programming pins
  input  wire  logic              PROG_SERIAL_CLOCK_PIN,
  input  wire  logic              PROG_SERIAL_DATA_PIN_IN,
  output var   logic              PROG_SERIAL_DATA_PIN_OUT,
  output var   logic              PROG_SERIAL_DATA_PIN_OE,
  output var   logic              PROG_ACTIVE
);

  // Frame layout of the serial port: 1 dir bit, address, then 16 data bits
  localparam int FRAME_W  = 1 + ADDR_W + PMTR_WORD_W;
  localparam int CNT_W    = $clog2(FRAME_W + 1);
  // Mask of implemented high-byte bits
  localparam logic [7:0] HI_MASK = 8'((16'h0001 << HI_BITS) - 16'h0001);

  // Synchronised programming pins
  logic              sck_s;       // Programming clock level
  logic              sda_s;       // Programming data level
  logic              sck_d;       // Previous clock level
  // Sequencer
  pmtr_state_type    state;       // Current state
  pmtr_state_type    next_state;  // Next state
  pmtr_req_type      req_q;       // Captured table request
  // Programming port shifter
  logic [FRAME_W-1:0] shreg;      // Shift register of the frame
  logic [CNT_W-1:0]   bitcnt;     // Bits taken in this frame
  logic [15:0]        rd_shift;   // Word being shifted back out
  logic               reading;    // Readback phase active
  logic               rd_load;    // Memory word of a read frame is ready to load
  // Memory port
  logic [ADDR_W-1:0] mem_addr;    // Address presented to memory
  logic [15:0]       mem_q;       // Registered memory word
  logic              mem_we;      // Load strobe from programming port

  // Pins pass two flops before any logic
  pmtr_sync u_sync_sck (
    .clk (CLK_SYS),
    .rst (RST),
    .d   (PROG_SERIAL_CLOCK_PIN),
    .q   (sck_s)
  );
  pmtr_sync u_sync_sda (
    .clk (CLK_SYS),
    .rst (RST),
    .d   (PROG_SERIAL_DATA_PIN_IN),
    .q   (sda_s)
  );

  // Decoded events and addresses
  wire               sck_rise   = sck_s & ~sck_d;
  wire               sck_fall   = ~sck_s & sck_d;
  wire               frame_full = (bitcnt == CNT_W'(FRAME_W));
  wire               frame_wr   = frame_full & ~shreg[FRAME_W-1];
  wire               frame_rd   = frame_full &  shreg[FRAME_W-1];
  wire [ADDR_W-1:0]  frame_addr = shreg[PMTR_WORD_W +: ADDR_W];
  wire [15:0]        frame_data = shreg[PMTR_WORD_W-1:0];
  // Full table address from both pointers
  wire [15:0]        tbl_full   = {TABLE_PTR_HI, TABLE_PTR_LO};
  // Alternate form: low pointer as offset into the last page
  wire [15:0]        tbl_page   = {8'((DEPTH >> 8) - 1), TABLE_PTR_LO};
  wire [15:0]        tbl_sel    = TABLE_REQ.alt ? tbl_page : tbl_full;
  // Basic form may only target sector 0
  wire               sect_ok    = TABLE_REQ.extended |
                                  (TABLE_REQ.dest_sect == PMTR_SECTOR_BASIC);
  wire               take_req   = TABLE_REQ.valid & sect_ok & (state == PMTR_ST_FETCH);
  logic [ADDR_W-1:0] tbl_addr;   // Table address held for the extra cycle
  wire [ADDR_W-1:0]  tbl_addr_w = tbl_sel[ADDR_W-1:0];

  // Memory port: programming address, reset vector, table address in the request cycle, fetch otherwise
  assign mem_addr = PROG_ACTIVE ? frame_addr :
                    (state == PMTR_ST_RESET) ? ADDR_W'(PMTR_RESET_VECTOR) :
                    take_req ? tbl_addr_w : FETCH_ADDR;
  assign mem_we   = PROG_ACTIVE & frame_wr;

  // Word memory with registered read data
  pmtr_rom #(
    .ADDR_W (ADDR_W)
  ) u_rom (
    .clk     (CLK_SYS),
    .wr_en   (mem_we),
    .wr_addr (frame_addr),
    .wr_data (frame_data),
    .rd_addr (mem_addr),
    .rd_data (mem_q)
  );

  // Next state of the sequencer
  always_comb begin
    next_state = state;
    case (state)
      PMTR_ST_RESET: next_state = PMTR_ST_FETCH;
      PMTR_ST_FETCH: begin
        if (take_req) begin
          next_state = PMTR_ST_TABLE;
        end
      end
      PMTR_ST_TABLE: next_state = PMTR_ST_FETCH;
      default:       next_state = PMTR_ST_RESET;
    endcase
  end

  // Sequencer and captured request; programming holds the core in reset entry
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      state    <= PMTR_ST_RESET;
      req_q    <= '0;
      tbl_addr <= '0;
    end else if (PROG_ACTIVE) begin
      state    <= PMTR_ST_RESET;
    end else begin
      state    <= next_state;
      if (take_req) begin
        req_q    <= TABLE_REQ;
        tbl_addr <= tbl_addr_w;
      end
    end
  end

  // Fetch outputs: the stalled cycle returns no instruction
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      FETCH_DATA  <= 16'h0000;
      FETCH_VALID <= 1'b0;
      FETCH_STALL <= 1'b0;
    end else begin
      FETCH_DATA  <= mem_q;
      FETCH_VALID <= ~PROG_ACTIVE & (state == PMTR_ST_FETCH) & ~take_req;
      FETCH_STALL <= take_req;
    end
  end

  // Table transfer: second cycle writes both bytes
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      TABLE_WR             <= '0;
      TABLE_BUSY           <= 1'b0;
      TABLE_REJECT         <= 1'b0;
      TABLE_HIGH_BYTE_HOLD <= PMTR_HOLD_RESET;
    end else begin
      TABLE_BUSY   <= take_req;
      TABLE_REJECT <= TABLE_REQ.valid & ~sect_ok;
      TABLE_WR     <= '0;
      if (state == PMTR_ST_TABLE) begin
        // Hardware transfer wins over a same-cycle software write
        TABLE_WR.valid       <= 1'b1;
        TABLE_WR.dest_addr   <= req_q.dest_addr;
        TABLE_WR.dest_sect   <= req_q.dest_sect;
        TABLE_WR.data        <= mem_q[PMTR_LO_LSB +: 8];
        TABLE_HIGH_BYTE_HOLD <= mem_q[PMTR_HI_LSB +: 8] & HI_MASK;
      end else if (HOLD_WR) begin
        TABLE_HIGH_BYTE_HOLD <= HOLD_WDATA;
      end
    end
  end

  // Serial programming: bits taken on rising clock, readback driven on falling
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      sck_d                    <= 1'b0;
      shreg                    <= '0;
      bitcnt                   <= '0;
      rd_shift                 <= 16'h0000;
      reading                  <= 1'b0;
      rd_load                  <= 1'b0;
      PROG_ACTIVE              <= 1'b0;
      PROG_SERIAL_DATA_PIN_OUT <= 1'b0;
      PROG_SERIAL_DATA_PIN_OE  <= 1'b0;
    end else begin
      sck_d   <= sck_s;
      rd_load <= frame_rd;
      // Registered memory needs one more cycle once the address is complete
      if (rd_load) begin
        rd_shift <= mem_q;
      end
      if (sck_rise & ~reading) begin
        PROG_ACTIVE <= 1'b1;
        shreg       <= {shreg[FRAME_W-2:0], sda_s};
        bitcnt      <= bitcnt + CNT_W'(1);
      end else if (frame_rd) begin
        // Word of this address is loaded on the next cycle
        reading  <= 1'b1;
        bitcnt   <= '0;
      end else if (frame_wr) begin
        bitcnt   <= '0;
      end
      if (reading & sck_fall) begin
        PROG_SERIAL_DATA_PIN_OE  <= 1'b1;
        PROG_SERIAL_DATA_PIN_OUT <= rd_shift[15];
        rd_shift                 <= {rd_shift[14:0], 1'b0};
        bitcnt                   <= bitcnt + CNT_W'(1);
        if (bitcnt == CNT_W'(PMTR_WORD_W)) begin
          reading                 <= 1'b0;
          PROG_SERIAL_DATA_PIN_OE <= 1'b0;
          bitcnt                  <= '0;
        end
      end
    end
  end

endmodule : pmtr_top
`default_nettype wire

// File: test/pmtr_prog_model.sv
// Serial programmer model that writes and reads program words over one data pin
`timescale 1ns/10ps
`default_nettype none
module pmtr_prog_model #(
  parameter int AW = 13                  // Word address width of the frame
) (
  output var  logic SCK,                 // Programmer clock, low between frames
  output var  logic SDA,                 // Level the programmer puts on the pin
  input  wire logic PIN                  // Resolved pin level
);
  initial begin
    SCK = 1'b0;
    SDA = 1'b0;
  end
  // One frame: direction bit, address, then 16 data bits, MSB first
  task automatic frame(input logic rd, input logic [AW-1:0] a, input logic [15:0] d, output logic [15:0] q);
    logic [AW+16:0] f;
    f = {rd, a, d};
    q = 16'h0000;
    for (int i = AW + 16; i >= 0; i--) begin
      // Released pin toggles so a stale level never passes for device data
      if (rd && i < 16) SDA = ~SDA;
      else SDA = f[i];
      #80 SCK = 1'b1;
      #80 SCK = 1'b0;
    end
    // Read frame: device drives bit 15 on the frame's last fall and the rest on the next falls; the 16th fall here releases
    if (rd) begin
      for (int k = 0; k < 17; k++) begin
        #80 SCK = 1'b1;
        if (k < 16) q = {q[14:0], PIN};
        #80 SCK = 1'b0;
      end
    end
    // Release the pin after the frame
    SDA = ~SDA;
  endtask : frame
endmodule : pmtr_prog_model
`default_nettype wire

// File: test/pmtr_top_sva.sv
// Checker of the table-read timing and the holding register of the program memory
`timescale 1ns/10ps
`default_nettype none
module pmtr_top_sva
  import pmtr_pkg::*;
#(
  parameter int HI_BITS = 8
) (
  input wire logic         CLK_SYS,
  input wire logic         RST,
  input wire logic         FETCH_VALID,
  input wire logic         FETCH_STALL,
  input wire pmtr_req_type TABLE_REQ,
  input wire pmtr_wr_type  TABLE_WR,
  input wire logic         TABLE_BUSY,
  input wire logic         TABLE_REJECT,
  input wire logic         HOLD_WR,
  input wire logic [7:0]   HOLD_WDATA,
  input wire logic [7:0]   TABLE_HIGH_BYTE_HOLD,
  input wire logic         PROG_ACTIVE,
  input wire logic         PROG_SERIAL_DATA_PIN_OE
);
  // Implemented bits of the high byte
  localparam logic [7:0] MASK = 8'hFF >> (8 - HI_BITS);
  // A request that the sequencer must take
  wire logic ok  = TABLE_REQ.extended || TABLE_REQ.dest_sect == PMTR_SECTOR_BASIC;
  wire logic acc = TABLE_REQ.valid && ok && !PROG_ACTIVE && !TABLE_BUSY;
  wire logic rej = TABLE_REQ.valid && !ok && !PROG_ACTIVE && !TABLE_BUSY;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  a_busy_after_req: assert property (acc |=> TABLE_BUSY && FETCH_STALL && !FETCH_VALID)
    else $error("busy or stall missing after table request");
  a_wr_two_cycles: assert property (acc |=> ##1 TABLE_WR.valid && TABLE_WR.dest_addr == $past(TABLE_REQ.dest_addr, 2)
    && TABLE_WR.dest_sect == $past(TABLE_REQ.dest_sect, 2))
    else $error("destination write not two cycles after request");
  a_wr_has_cause: assert property (TABLE_WR.valid |-> $past(TABLE_BUSY))
    else $error("destination write without busy cycle");
  a_busy_one_cycle: assert property (TABLE_BUSY |=> !TABLE_BUSY)
    else $error("busy longer than one cycle");
  a_hold_masked: assert property (TABLE_WR.valid |-> (TABLE_HIGH_BYTE_HOLD & ~MASK) == 8'h00)
    else $error("unimplemented hold bits not zero");
  a_reject_basic: assert property (rej |=> TABLE_REJECT && !TABLE_BUSY ##1 !TABLE_WR.valid)
    else $error("basic read outside sector zero not refused");
  a_hold_sw_write: assert property (HOLD_WR && !TABLE_BUSY |=> TABLE_HIGH_BYTE_HOLD == $past(HOLD_WDATA))
    else $error("software write of hold lost");
  a_hold_stays: assert property (!HOLD_WR && !TABLE_BUSY |=> $stable(TABLE_HIGH_BYTE_HOLD))
    else $error("hold changed without cause");
  a_oe_idle: assert property (!PROG_ACTIVE |-> !PROG_SERIAL_DATA_PIN_OE)
    else $error("data pin driven outside programming");
  c_accept: cover property (acc);
  c_reject: cover property (rej);
  c_pin_out: cover property (PROG_SERIAL_DATA_PIN_OE);
endmodule : pmtr_top_sva
bind pmtr_top pmtr_top_sva #(.HI_BITS(HI_BITS)) u_sva (.*);
`default_nettype wire

// File: test/program_memory_table_read_test.sv
// Self-checking bench of table reads, reset fetch and serial programming
`timescale 1ns/10ps
`default_nettype none
module program_memory_table_read_test;
  import pmtr_pkg::*;
  // One table read: form, pointers, destination and expected bytes
  typedef struct packed {
    logic ext, alt;
    logic [7:0] sect, hi, lo, elo, ehi;
  } pmtr_row_type;
  logic clk = 0, rst = 1, hold_wr = 0, fetch_valid, fetch_stall, busy, reject, sck, m_sda, dout, doe, pact;
  logic [12:0] fetch_addr = 0;
  logic [15:0] fetch_data, q;
  logic [7:0] lo = 0, hi = 0, hold_wdata = 0, hold;
  pmtr_req_type req = '0;
  pmtr_wr_type wr;
  int fails = 0, num_checks = 0, n;
  // Pin level: device when enabled, else the programmer
  wire logic din = doe ? dout : m_sda;
  // High byte masked to 6 implemented bits
  pmtr_row_type rows [4] = '{
    '{1'b0, 1'b0, 8'h00, 8'h03, 8'h05, 8'hF7, 8'h03},
    '{1'b0, 1'b1, 8'h00, 8'h03, 8'h06, 8'h1A, 8'h2B},
    '{1'b1, 1'b0, 8'h05, 8'h1F, 8'h06, 8'h1A, 8'h2B},
    '{1'b1, 1'b1, 8'h07, 8'h00, 8'h05, 8'h0B, 8'h3E}};
  pmtr_top #(.DEPTH(8192), .ADDR_W(13), .HI_BITS(6)) dut (.CLK_SYS(clk), .RST(rst), .FETCH_ADDR(fetch_addr),
    .FETCH_DATA(fetch_data), .FETCH_VALID(fetch_valid), .FETCH_STALL(fetch_stall), .TABLE_PTR_LO(lo),
    .TABLE_PTR_HI(hi), .TABLE_REQ(req), .TABLE_WR(wr), .TABLE_BUSY(busy), .TABLE_REJECT(reject),
    .HOLD_WR(hold_wr), .HOLD_WDATA(hold_wdata), .TABLE_HIGH_BYTE_HOLD(hold), .PROG_SERIAL_CLOCK_PIN(sck),
    .PROG_SERIAL_DATA_PIN_IN(din), .PROG_SERIAL_DATA_PIN_OUT(dout), .PROG_SERIAL_DATA_PIN_OE(doe),
    .PROG_ACTIVE(pact));
  pmtr_prog_model #(.AW(13)) u_prog (.SCK(sck), .SDA(m_sda), .PIN(din));
  // 125 MHz clock
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] s);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, e, s);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  // Reset held five cycles, driven at the falling edge
  task automatic do_reset;
    @(negedge clk) rst = 1;
    repeat (5) @(negedge clk);
    rst = 0;
  endtask : do_reset
  // Request at c0, busy at c1, write and hold at c2, fetching back at c3
  task automatic tread(input pmtr_row_type r, input logic [7:0] d);
    @(negedge clk);
    req = '{1'b1, r.ext, r.alt, d, r.sect};
    lo = r.lo;
    hi = r.hi;
    @(negedge clk) req.valid = 0;
    chk("busy", 16'h1, {15'h0, busy && fetch_stall && !fetch_valid});
    @(negedge clk) chk("wr", {1'b1, d, r.sect}, {wr.valid, wr.dest_addr, wr.dest_sect});
    chk("low byte", {8'h00, r.elo}, {8'h00, wr.data});
    chk("hold", {8'h00, r.ehi}, {8'h00, hold});
    @(negedge clk) chk("fetch back", 16'h1, {15'h0, fetch_valid});
  endtask : tread
  initial begin
    do_reset();
    chk("hold reset", {8'h00, PMTR_HOLD_RESET}, {8'h00, hold});
    // Load words through the serial port, then read one back
    u_prog.frame(1'b0, 13'h0000, 16'h1234, q);
    u_prog.frame(1'b0, 13'h0305, 16'hC3F7, q);
    u_prog.frame(1'b0, 13'h1F06, 16'hAB1A, q);
    u_prog.frame(1'b0, 13'h1F05, 16'h7E0B, q);
    u_prog.frame(1'b1, 13'h0305, 16'h0000, q);
    chk("serial read", 16'hC3F7, q);
    // Memory survives reset; first word comes from the reset vector
    do_reset();
    repeat (3) @(negedge clk);
    chk("reset fetch", 16'h1234, fetch_data);
    chk("fetch valid", 16'h1, {15'h0, fetch_valid && !pact});
    foreach (rows[i]) tread(rows[i], 8'h40 + 8'(i));
    // Basic form to sector 2 is refused with no write
    @(negedge clk) req = '{1'b1, 1'b0, 1'b0, 8'h50, 8'h02};
    @(negedge clk) req.valid = 0;
    n = 0;
    while (reject !== 1'b1 && n < 3) @(negedge clk) n++;
    if (n == 3) begin
      chk("reject", 16'h1, 16'h0);
      wrap_up();
    end
    // Valid held two cycles: the repeat during the table cycle is ignored
    @(negedge clk) req = '{1'b1, 1'b1, 1'b0, 8'h60, 8'h03};
    @(negedge clk);
    @(negedge clk) begin
      req.valid = 0;
      n = int'(wr.valid);
    end
    repeat (3) @(negedge clk) n += int'(wr.valid);
    chk("one write", 16'h1, 16'(n));
    // Software write of the hold register
    @(negedge clk) {hold_wr, hold_wdata} = {1'b1, 8'hA5};
    @(negedge clk) hold_wr = 0;
    chk("hold write", 16'h00A5, {8'h00, hold});
    wrap_up();
  end
endmodule : program_memory_table_read_test
`default_nettype wire
